// ### src/tsw_pkg.sv
// constants, register map and types shared by the two-stage watchdog files
// assumes a 25 MHz ref_clk_i and a 32-bit AHB-Lite register port
package tsw_pkg;

    // clock and timebases
    localparam int CLK_HZ  = 25_000_000;
    localparam int TB1_HZ  = 32_768;
    localparam int TB2_HZ  = 10_000;
    localparam int TB1_DIV = (CLK_HZ + TB1_HZ / 2) / TB1_HZ;
    localparam int TB2_DIV = CLK_HZ / TB2_HZ;

    // counter and option field widths
    localparam int STG1_W = 16;
    localparam int STG2_W = 8;
    localparam int OPT_W  = 7;

    // register byte offsets
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_RELOAD1 = 8'h04;
    localparam logic [7:0] ADDR_RELOAD2 = 8'h08;
    localparam logic [7:0] ADDR_OPTIONS = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_COUNT   = 8'h14;

    // command bits
    localparam int CMD_ARM     = 0;
    localparam int CMD_DISABLE = 1;
    localparam int CMD_RETRIG  = 2;

    // option flags, first variant
    localparam logic [OPT_W-1:0] V1_SCI   = 7'h01;
    localparam logic [OPT_W-1:0] V1_NMI   = 7'h02;
    localparam logic [OPT_W-1:0] V1_SMI   = 7'h04;
    localparam logic [OPT_W-1:0] V1_RST   = 7'h08;
    localparam logic [OPT_W-1:0] V1_FALL  = 7'h10;
    localparam logic [OPT_W-1:0] V1_EARLY = 7'h20;
    localparam logic [OPT_W-1:0] V1_HWEN  = 7'h40;

    // option flags, second variant
    localparam logic [OPT_W-1:0] V2_HWEN  = 7'h01;
    localparam logic [OPT_W-1:0] V2_FALL  = 7'h02;
    localparam logic [OPT_W-1:0] V2_EARLY = 7'h04;
    localparam logic [OPT_W-1:0] V2_RST   = 7'h08;
    localparam logic [OPT_W-1:0] V2_NMI   = 7'h10;
    localparam logic [OPT_W-1:0] OPT_NONE = 7'h00;

    typedef enum logic [1:0] {
        TSW_OFF,
        TSW_STAGE1,
        TSW_STAGE2,
        TSW_FIRED
    } tsw_state_t;

endpackage : tsw_pkg

// ### src/tsw_stage_cnt.sv
// one watchdog stage: reloadable down-counter with expiry flag
// assumes tick_i is a one-cycle pulse from tsw_tick
`timescale 1ns/1ps
module tsw_stage_cnt #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         load_i,
    input  wire logic [W-1:0] reload_i,
    input  wire logic         en_i,
    input  wire logic         tick_i,
    // status
    output logic [W-1:0]      count_o,
    output logic              expired_o
);
    import tsw_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } tsw_cnt_st_t;

    tsw_cnt_st_t q, d;

    assign count_o   = q.cnt;
    assign expired_o = en_i && (q.cnt == '0); // RULE_20

    always_comb begin
        d = q;
        if (load_i) begin
            d.cnt = reload_i;
        end else if (en_i && tick_i && q.cnt != '0) begin
            d.cnt = q.cnt - W'(1); // RULE_20
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    count_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_20
        en_i && tick_i && !load_i && q.cnt != '0 |=> q.cnt == $past(q.cnt) - W'(1))
        else $error("stage counter did not step down on tick");

endmodule : tsw_stage_cnt

// ### src/tsw_tick.sv
// timebase tick generator for the watchdog stages
// assumes run_i is low whenever the prescaler must restart
`timescale 1ns/1ps
module tsw_tick #(
    parameter int DIV = 763
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic run_i,
    output logic      tick_o
);
    import tsw_pkg::*;

    typedef struct packed {
        logic [11:0] cnt;
    } tsw_tick_st_t;

    localparam logic [11:0] LAST = 12'(DIV - 1);

    tsw_tick_st_t q, d;

    assign tick_o = run_i && (q.cnt == LAST);

    always_comb begin
        d = q;
        if (!run_i || q.cnt == LAST) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    tick_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_20
        tick_o |=> !tick_o) else $error("tick asserted twice in a row");

endmodule : tsw_tick

// ### src/tsw_top.sv
// two-stage watchdog with AHB-Lite register port
// assumes a single AHB-Lite master; retrigger pin is asynchronous to ref_clk_i
// Notes on behaviour
// RULE_01 - variant one: 16-bit first stage ticking at 32.768 kHz
// RULE_02 - variant two: both stages tick at 10 kHz, first stage stays 16 bits
// RULE_03 - armed circuit forces hard reset unless disarmed or retriggered in time
// RULE_04 - first-stage expiry drives the warning output
// RULE_05 - first-stage expiry starts the second stage
// RULE_06 - variant one: expiry raises selected NMI, SYSTEM_CONTROLLER_IRQ, SYSTEM_MANAGEMENT_IRQ and reset
// RULE_07 - variant two: expiry raises selected NMI and reset
// RULE_08 - software retrigger is accepted once armed, until the second stage runs, and restarts the first stage
// RULE_09 - enabled hardware retrigger pin restarts first stage, else ignored
// RULE_10 - second stage has an 8-bit reload on the same timebase
// RULE_11 - second-stage expiry always produces hardware reset
// RULE_12 - once second stage runs, only disable prevents the reset
// RULE_13 - variant one option flag bit assignments
// RULE_14 - variant two option flag bit assignments
// RULE_15 - arm loads both reloads, applies options, then arms
// RULE_16 - disable stops both stages and all outputs
// RULE_17 - retrigger reloads both counters with their reload values
// RULE_18 - software retrigger while disabled re-enables with the last armed setup
// RULE_19 - software must arm before any retrigger
// RULE_20 - armed stage counts down once per tick, expires at zero
`timescale 1ns/1ps
module tsw_top #(
    parameter bit VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // watchdog pins
    input  wire logic        retrigger_input_i,
    output logic             warning_output_o,
    output logic             nmi_o,
    output logic             system_controller_irq_o,
    output logic             system_management_irq_o,
    output logic             hw_reset_o
);
    import tsw_pkg::*;

    // option decode per variant
    localparam logic [OPT_W-1:0] M_SCI   = VARIANT ? OPT_NONE : V1_SCI;   // RULE_13
    localparam logic [OPT_W-1:0] M_SMI   = VARIANT ? OPT_NONE : V1_SMI;   // RULE_13
    localparam logic [OPT_W-1:0] M_NMI   = VARIANT ? V2_NMI   : V1_NMI;   // RULE_14
    localparam logic [OPT_W-1:0] M_RST   = VARIANT ? V2_RST   : V1_RST;   // RULE_14
    localparam logic [OPT_W-1:0] M_FALL  = VARIANT ? V2_FALL  : V1_FALL;  // RULE_14
    localparam logic [OPT_W-1:0] M_EARLY = VARIANT ? V2_EARLY : V1_EARLY; // RULE_14
    localparam logic [OPT_W-1:0] M_HWEN  = VARIANT ? V2_HWEN  : V1_HWEN;  // RULE_14
    localparam int TB_DIV = VARIANT ? TB2_DIV : TB1_DIV; // RULE_01 RULE_02

    typedef struct packed {
        tsw_state_t        st;
        logic              cfg;
        logic              wr_pend;
        logic [7:0]        waddr;
        logic [STG1_W-1:0] rl1_stg;
        logic [STG2_W-1:0] rl2_stg;
        logic [OPT_W-1:0]  opt_stg;
        logic [STG1_W-1:0] rl1;
        logic [STG2_W-1:0] rl2;
        logic [OPT_W-1:0]  opt;
        logic              sync1;
        logic              sync2;
        logic              sync3;
        logic [31:0]       rdata;
        logic              warn;
        logic              nmi;
        logic              system_controller_irq;
        logic              system_management_irq;
        logic              hrst;
    } tsw_top_st_t;

    tsw_top_st_t q, d;

    logic              arm;
    logic              dis;
    logic              sw_trig;
    logic              hw_edge;
    logic              hw_trig;
    logic              load;
    logic              late;
    logic              rd_take;
    logic [STG1_W-1:0] rl1_new;
    logic [STG2_W-1:0] rl2_new;
    logic              tick;
    logic              exp1;
    logic              exp2;
    logic [STG1_W-1:0] cnt1;
    logic [STG2_W-1:0] cnt2;

    assign hreadyout_o             = 1'b1;
    assign hresp_o                 = 1'b0;
    assign hrdata_o                = q.rdata;
    assign warning_output_o        = q.warn;
    assign nmi_o                   = q.nmi;
    assign system_controller_irq_o = q.system_controller_irq;
    assign system_management_irq_o = q.system_management_irq;
    assign hw_reset_o              = q.hrst;

    tsw_tick #(
        .DIV (TB_DIV)
    ) u_tick (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .run_i     ((q.st == TSW_STAGE1 || q.st == TSW_STAGE2) && !load),
        .tick_o    (tick)
    );

    tsw_stage_cnt #(
        .W (STG1_W)
    ) u_stage1 (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (load),
        .reload_i  (rl1_new),
        .en_i      (q.st == TSW_STAGE1),
        .tick_i    (tick),
        .count_o   (cnt1),
        .expired_o (exp1)
    );

    tsw_stage_cnt #(
        .W (STG2_W)
    ) u_stage2 (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (load),
        .reload_i  (rl2_new),
        .en_i      (q.st == TSW_STAGE2),
        .tick_i    (tick),
        .count_o   (cnt2),
        .expired_o (exp2)
    );

    always_comb begin
        d       = q;
        arm     = 1'b0;
        dis     = 1'b0;
        sw_trig = 1'b0;
        load    = 1'b0;
        rl1_new = q.rl1;
        rl2_new = q.rl2;

        // bus: write data phase
        rd_take   = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
        d.wr_pend = hsel_i && htrans_i[1] && hready_i && hwrite_i;
        d.waddr   = haddr_i[7:0];
        if (q.wr_pend) begin
            case (q.waddr)
                ADDR_CMD: begin
                    arm     = hwdata_i[CMD_ARM];
                    dis     = hwdata_i[CMD_DISABLE];
                    sw_trig = hwdata_i[CMD_RETRIG]; // RULE_08
                end
                ADDR_RELOAD1: d.rl1_stg = hwdata_i[STG1_W-1:0];
                ADDR_RELOAD2: d.rl2_stg = hwdata_i[STG2_W-1:0];
                ADDR_OPTIONS: d.opt_stg = hwdata_i[OPT_W-1:0];
                default: ;
            endcase
        end

        // bus: read data captured at the address phase
        d.rdata = '0;
        if (rd_take) begin
            case (haddr_i[7:0])
                ADDR_RELOAD1: d.rdata = {16'h0000, q.rl1_stg};
                ADDR_RELOAD2: d.rdata = {24'h000000, q.rl2_stg};
                ADDR_OPTIONS: d.rdata = {25'h0000000, q.opt_stg};
                ADDR_STATUS:  d.rdata = {29'h00000000, q.cfg, q.st};
                ADDR_COUNT:   d.rdata = {8'h00, cnt2, cnt1};
                default:      d.rdata = '0;
            endcase
        end

        // retrigger pin: two-stage sync, then edge detect
        d.sync1 = retrigger_input_i;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        hw_edge = |(q.opt & M_FALL) ? (q.sync3 && !q.sync2) : (!q.sync3 && q.sync2);
        hw_trig = hw_edge && |(q.opt & M_HWEN); // RULE_09

        if (dis) begin
            d.st = TSW_OFF; // RULE_16 RULE_12
        end else if (arm) begin
            d.rl1 = q.rl1_stg; // RULE_15
            d.rl2 = q.rl2_stg;
            d.opt = q.opt_stg;
            d.cfg = 1'b1;
            if (q.st == TSW_OFF || q.st == TSW_STAGE1) begin
                rl1_new = q.rl1_stg;
                rl2_new = q.rl2_stg;
                load    = 1'b1;
                d.st    = TSW_STAGE1; // RULE_03
            end
        end else if (sw_trig && q.cfg && q.st == TSW_OFF) begin
            load = 1'b1; // RULE_18 RULE_19
            d.st = TSW_STAGE1;
        end else if ((sw_trig || hw_trig) && q.st == TSW_STAGE1) begin
            load = 1'b1; // RULE_17 RULE_08 RULE_09
        end else begin
            case (q.st)
                TSW_STAGE1: if (exp1) d.st = TSW_STAGE2; // RULE_05
                TSW_STAGE2: if (exp2) d.st = TSW_FIRED;  // RULE_10
                default: ;
            endcase
        end

        // pin outputs follow the next state
        late   = (d.st == TSW_STAGE2) || (d.st == TSW_FIRED);
        d.nmi  = late && |(d.opt & M_NMI); // RULE_06 RULE_07
        d.system_controller_irq  = late && |(d.opt & M_SCI); // RULE_06
        d.system_management_irq  = late && |(d.opt & M_SMI); // RULE_06
        d.hrst = (d.st == TSW_FIRED) || (late && |(d.opt & M_RST)); // RULE_11 RULE_03
        if (|(d.opt & M_EARLY)) begin
            d.warn = late; // RULE_04
        end else begin
            d.warn = (q.st == TSW_STAGE1) && (d.st == TSW_STAGE2); // RULE_04
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // checks
    logic quiet;
    assign quiet = !arm && !dis && !sw_trig && !hw_trig;

    sequence arm_seq;
        arm && !dis && q.st == TSW_OFF;
    endsequence

    sequence armed_seq;
        q.st == TSW_STAGE1 && q.cfg;
    endsequence

    expire_warn_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_04
        q.st == TSW_STAGE1 && exp1 && quiet |=> warning_output_o)
        else $error("warning not driven at first-stage expiry");

    stage2_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_05
        q.st == TSW_STAGE1 && exp1 && quiet |=> q.st == TSW_STAGE2 ##1 cnt2 == q.rl2
        || q.st != TSW_STAGE2) else $error("second stage did not start");

    final_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_11
        q.st == TSW_STAGE2 && exp2 && !dis |=> hw_reset_o [*2])
        else $error("no hardware reset after second-stage expiry");

    stage2_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_12
        q.st == TSW_STAGE2 && !dis |=> q.st == TSW_STAGE2 || q.st == TSW_FIRED)
        else $error("second stage left without disable");

    disable_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_16
        dis |=> q.st == TSW_OFF && !hw_reset_o && !nmi_o && !warning_output_o)
        else $error("outputs active after disable");

    arm_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_15
        arm_seq |=> armed_seq ##0 cnt1 == q.rl1 && cnt2 == q.rl2)
        else $error("arm did not load and start");

    retrig_reload_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_17
        q.st == TSW_STAGE1 && (sw_trig || hw_trig) && !arm && !dis
        |=> cnt1 == q.rl1 && cnt2 == q.rl2) else $error("retrigger did not reload");

    reenable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_18
        q.st == TSW_OFF && q.cfg && sw_trig && !arm && !dis |=> armed_seq)
        else $error("retrigger did not re-enable");

    hw_ignored_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
        hw_edge && !(|(q.opt & M_HWEN)) && !sw_trig && !arm |-> !load)
        else $error("disabled pin retrigger acted");

    nmi_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_07
        q.st == TSW_STAGE2 |-> nmi_o == |(q.opt & M_NMI))
        else $error("nmi output does not follow option");

    sci_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
        q.st == TSW_STAGE2 |-> system_controller_irq_o == |(q.opt & M_SCI))
        else $error("sci output does not follow option");

    smi_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
        q.st == TSW_STAGE2 |-> system_management_irq_o == |(q.opt & M_SMI))
        else $error("smi output does not follow option");

    reset_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_07
        q.st == TSW_STAGE2 |-> hw_reset_o == |(q.opt & M_RST))
        else $error("early reset does not follow option");

    fired_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_11
        q.st == TSW_FIRED |-> hw_reset_o)
        else $error("reset missing after second-stage expiry");

    off_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_16
        q.st == TSW_OFF |-> !hw_reset_o && !nmi_o && !system_controller_irq_o
        && !system_management_irq_o && !warning_output_o) else $error("output active when off");

    unarmed_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_18
        q.st == TSW_OFF && !q.cfg && !arm |=> q.st == TSW_OFF)
        else $error("watchdog started without an arm");

    stage2_retrig_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_12
        q.st == TSW_STAGE2 && (sw_trig || hw_trig) && !dis |=> q.st != TSW_STAGE1)
        else $error("retrigger restarted a running second stage");

    stage2_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
        q.st == TSW_STAGE2 && tick && cnt2 != '0 |=> cnt2 == $past(cnt2) - 8'h01)
        else $error("second stage did not step on tick");

    stage1_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_20
        q.st == TSW_STAGE1 && !tick && !load |=> $stable(cnt1))
        else $error("first stage moved without a tick");

    stage2_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_05
        q.st == TSW_STAGE1 && !load |=> $stable(cnt2))
        else $error("second stage counted before first-stage expiry");

    warn_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_04
        warning_output_o && !(|(q.opt & M_EARLY)) && !arm |=> !warning_output_o)
        else $error("warning pulse longer than one cycle");

    early_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_04
        (q.st == TSW_STAGE2 || q.st == TSW_FIRED) && |(q.opt & M_EARLY) |-> warning_output_o)
        else $error("warning level missing");

    pin_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
        q.st == TSW_OFF && hw_trig && !sw_trig && !arm |=> q.st == TSW_OFF)
        else $error("pin retrigger woke a disabled watchdog");

    tick_space_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01 RULE_02
        tick |=> !tick [*8])
        else $error("timebase ticks too close together");

endmodule : tsw_top

// ### testbench/test_two_stage_watchdog.sv
// self-checking bench for tsw_top, both variants sharing one AHB-Lite bus
// assumes tsw_pkg constants and zero-wait-state slave timing
`timescale 1ns/1ps
module test_two_stage_watchdog;
    import tsw_pkg::*;
    localparam int T = TB1_DIV;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic [1:0]  htrans    = 2'b00;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic        alive     = 1'b0;
    logic        fall      = 1'b0;
    logic [15:0] period    = 16'h0100;
    logic        hready, hresp, pin, warning_output, nmi, system_controller_irq, system_management_irq, hrst;
    logic [31:0] hrdata, rd_smp;
    logic        wdo2, nmi2, sci2, smi2, hrst2;
    logic [31:0] seed      = 32'd37;
    int          error_cnt = 0;
    int          checks_done = 0;

    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) rd_smp <= hrdata;

    tsw_top #(.VARIANT(1'b0)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .retrigger_input_i(pin), .warning_output_o(warning_output), .nmi_o(nmi),
        .system_controller_irq_o(system_controller_irq), .system_management_irq_o(system_management_irq), .hw_reset_o(hrst)
    );
    tsw_ext_dev ext (
        .ref_clk_i(ref_clk_i), .alive_i(alive), .fall_i(fall), .period_i(period), .pin_o(pin)
    );
    // second variant listens to the same writes; only its pins are checked
    tsw_top #(.VARIANT(1'b1)) dut2 (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(), .hresp_o(), .hrdata_o(),
        .retrigger_input_i(pin), .warning_output_o(wdo2), .nmi_o(nmi2),
        .system_controller_irq_o(sci2), .system_management_irq_o(smi2), .hw_reset_o(hrst2)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] stat(input logic cfg, input tsw_state_t s);
        return {29'h0, cfg, s};
    endfunction : stat
    function automatic logic [31:0] cnt_exp(input logic [15:0] a, input logic [7:0] b);
        return {8'h00, b, a};
    endfunction : cnt_exp

    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge ref_clk_i);
        while (hready !== 1'b1) @(posedge ref_clk_i);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk_i);
        while (hready !== 1'b1) @(posedge ref_clk_i);
        #1;
        rd = rd_smp;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc
    task automatic wait_sig(input bit rst_sig, input int lim, input string nm);
        int n;
        n = 0;
        while (n < lim && (rst_sig ? hrst : warning_output) !== 1'b1) begin
            cyc(1);
            n++;
        end
        chk(nm, 32'h1, {31'h0, rst_sig ? hrst : warning_output});
    endtask : wait_sig
    task automatic setup(input logic [15:0] a, input logic [7:0] b, input logic [6:0] o);
        wr(ADDR_RELOAD1, {16'h0, a});
        wr(ADDR_RELOAD2, {24'h0, b});
        wr(ADDR_OPTIONS, {25'h0, o});
        rdc("options", ADDR_OPTIONS, {25'h0, o});
        wr(ADDR_CMD, 32'h1 << CMD_ARM);
        rdc("count", ADDR_COUNT, cnt_exp(a, b));
    endtask : setup
    task automatic quiet();
        wr(ADDR_CMD, 32'h1 << CMD_DISABLE);
        cyc(2);
        chk("outputs", 32'h0, {27'h0, warning_output, nmi, system_controller_irq, system_management_irq, hrst});
        rdc("status", ADDR_STATUS, stat(1'b1, TSW_OFF));
    endtask : quiet

    initial begin
        logic [6:0]  op;
        logic [15:0] r1;
        logic [7:0]  r2;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc("status", ADDR_STATUS, stat(1'b0, TSW_OFF));
        wr(8'h40, 32'hffff_ffff);
        rdc("unmapped", 8'h40, 32'h0);
        // expiry rounds: every output flag first, then random selections
        for (int i = 0; i < 3; i++) begin
            op = (i == 0) ? 7'h2f : (7'(rnd()) & 7'h2f);
            r1 = 16'(2 + rnd() % 3);
            r2 = 8'(1 + rnd() % 3);
            setup(r1, r2, op);
            rdc("status", ADDR_STATUS, stat(1'b1, TSW_STAGE1));
            cyc(r1 * T - 40);
            chk("early", 32'h0, {31'h0, warning_output});
            wait_sig(1'b0, 90, "warning");
            cyc(2);
            chk("irq", {28'h0, op[3], op[2], op[0], op[1]}, {28'h0, hrst, system_management_irq, system_controller_irq, nmi});
            chk("level", {31'h0, op[5]}, {31'h0, warning_output});
            rdc("status", ADDR_STATUS, stat(1'b1, TSW_STAGE2));
            wr(ADDR_CMD, 32'h1 << CMD_RETRIG);
            cyc(r2 * T - 20);
            chk("pre-reset", {31'h0, op[3]}, {31'h0, hrst});
            cyc(30);
            wait_sig(1'b1, 10, "reset");
            rdc("status", ADDR_STATUS, stat(1'b1, TSW_FIRED));
            quiet();
        end
        // retrigger while disabled, then software keep-alive
        wr(ADDR_CMD, 32'h1 << CMD_RETRIG);
        rdc("status", ADDR_STATUS, stat(1'b1, TSW_STAGE1));
        for (int i = 0; i < 4; i++) begin
            cyc(r1 * T - 150);
            wr(ADDR_CMD, 32'h1 << CMD_RETRIG);
            rdc("count", ADDR_COUNT, cnt_exp(r1, r2));
            rdc("status", ADDR_STATUS, stat(1'b1, TSW_STAGE1));
        end
        quiet();
        // pin keep-alive on both edges, then with the pin disabled
        for (int k = 0; k < 3; k++) begin
            fall <= (k == 1);
            period <= 16'(r1 * T / 2);
            op = (k == 2) ? OPT_NONE : (V1_HWEN | ((k == 1) ? V1_FALL : OPT_NONE));
            cyc(2);
            alive <= 1'b1;
            setup(r1, r2, op);
            if (k < 2) begin
                cyc(2 * r1 * T);
                rdc("status", ADDR_STATUS, stat(1'b1, TSW_STAGE1));
                alive <= 1'b0;
            end
            wait_sig(1'b0, r1 * T + 200, "warning");
            alive <= 1'b0;
            quiet();
        end
        // second variant: own timebase and flag places on the same bus
        setup(r1, r2, V2_NMI | V2_RST);
        cyc(r1 * TB2_DIV - 40);
        chk("v2 early", 32'h0, {31'h0, wdo2});
        for (int n = 0; n < 90 && wdo2 !== 1'b1; n++) begin
            cyc(1);
        end
        chk("v2 warning", 32'h1, {31'h0, wdo2});
        cyc(2);
        chk("v2 irq", 32'hc, {28'h0, hrst2, nmi2, sci2, smi2});
        quiet();
        chk("v2 off", 32'h0, {27'h0, wdo2, nmi2, sci2, smi2, hrst2});
        end_sim();
    end

    initial begin
        repeat (90000) @(posedge ref_clk_i);
        error_cnt++;
        end_sim();
    end
endmodule : test_two_stage_watchdog

// ### testbench/tsw_ext_dev.sv
// external supervisory device that pulses the retrigger pin while kept alive
// assumes period_i is well above the eight-cycle pulse width
`timescale 1ns/1ps
module tsw_ext_dev (
    // clock
    input  wire logic        ref_clk_i,
    // control from the bench
    input  wire logic        alive_i,
    input  wire logic        fall_i,
    input  wire logic [15:0] period_i,
    // retrigger pin
    output logic             pin_o
);
    logic [15:0] cnt_q = 16'h0000;
    initial pin_o = 1'b0;
    always @(posedge ref_clk_i) begin
        cnt_q <= (!alive_i || cnt_q >= period_i) ? 16'h0000 : cnt_q + 16'h0001;
        // idle at the inactive level, active for eight cycles each period
        pin_o <= fall_i ^ (alive_i && cnt_q < 16'h0008);
    end
endmodule : tsw_ext_dev
